// ### design/adc_seq_pkg.sv
`default_nettype none
package adc_seq_pkg;

    // Register byte offsets
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_STATUS = 8'h04;
    localparam logic [7:0] OFF_NMASK = 8'h08;
    localparam logic [7:0] OFF_JMASK = 8'h0C;
    localparam logic [7:0] OFF_PEND = 8'h10;
    localparam logic [7:0] OFF_LOST = 8'h14;
    localparam logic [7:0] OFF_RESULT = 8'h20;

    // Control field positions
    localparam int CTRL_NORMAL_CHAIN_RUNNING_FLAG = 0;
    localparam int CTRL_INJECTED_CHAIN_RUNNING_FLAG = 1;
    localparam int CTRL_SCAN = 2;
    localparam int CTRL_DIV_LSB = 4;
    localparam int DIV_W = 4;

    // Status field positions
    localparam int STAT_NRUN = 0;
    localparam int STAT_JRUN = 1;
    localparam int STAT_TPEND = 2;
    localparam int STAT_CH_LSB = 8;

    // Result word valid bit
    localparam int RES_VALID = 31;

    // Values after reset
    localparam logic [DIV_W-1:0] DIV_FULL_RATE = 4'h0;
    localparam logic [31:0] WORD_RST = 32'h0000_0000;

    // Phase lengths in clock cycles
    localparam logic [3:0] SAMPLE_CYCLES = 4'h4;
    localparam logic [3:0] CONVERT_CYCLES = 4'hA;

    // Default channel count and result width
    localparam int NUM_CH_DEF = 8;
    localparam int DATA_W_DEF = 10;

    // Converter phase, one-hot
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_SAMPLE = 3'b010,
        ST_CONVERT = 3'b100
    } seq_state_type;

    // Kind of chain in service
    typedef enum logic [1:0] {
        K_NORM = 2'h0,
        K_INJ = 2'h1,
        K_TRIG = 2'h2
    } chain_kind_type;

endpackage
`default_nettype wire

// ### design/body_trigger_unit.sv
`timescale 1ns/1ps
`default_nettype none

// Forwards timer and other trigger requests; timer channel number forwarded only at full rate
module body_trigger_unit #(
    parameter int CHW = 3
) (
    // System
    input wire logic clock,
    input wire logic srst,
    // Clock divider setting of this unit
    input wire logic [adc_seq_pkg::DIV_W-1:0] trigger_clock_divider,
    // Periodic interval timer source
    input wire logic timer_req,
    input wire logic [CHW-1:0] timer_ch,
    // Non-timer source
    input wire logic ext_req,
    input wire logic [CHW-1:0] ext_ch,
    // Forwarded request
    output logic req,
    output logic [CHW-1:0] ch
);

    logic req_q; // Forwarded request pulse
    logic [CHW-1:0] ch_q; // Forwarded channel
    logic [CHW-1:0] last_q; // Channel of last non-timer request
    logic divided; // Unit runs slower than system clock

    assign divided = trigger_clock_divider != adc_seq_pkg::DIV_FULL_RATE;
    assign req = req_q;
    assign ch = ch_q;

    // Request always forwarded; timer channel lost when divided
    always_ff @(posedge clock) begin
        if (srst) begin
            req_q <= 1'b0;
            ch_q <= '0;
            last_q <= '0;
        end else begin
            req_q <= ext_req || timer_req;
            if (ext_req) begin
                ch_q <= ext_ch;
                last_q <= ext_ch;
            end else if (timer_req) begin
                // Stale channel, zero before any other request
                ch_q <= divided ? last_q : timer_ch;
            end
        end
    end

    AST_TIMER_FORWARDED: assert property (@(posedge clock) disable iff (srst)
        timer_req |=> req) else $error("timer request not forwarded");

    AST_STALE_CHANNEL: assert property (@(posedge clock) disable iff (srst)
        timer_req && !ext_req && divided |=> ch == $past(last_q))
        else $error("divided timer channel not stale");

endmodule

`default_nettype wire

// ### design/adc_chain_sequencer.sv
// Behaviour
// - Injected or trigger requests preempt running conversions
// - Preempted conversion-phase sample is discarded, lost
// - Lost sample sets neither valid nor pending
// - Last-channel preemption may give two end events
// - Sampling preemption: channel restored; immediate end event only if it is the last channel
// - Scan mode: conversion preemption gives no second event
// - One-shot: last-channel conversion preemption restarts whole chain, else next channel follows
// - Running flags stay set while more events follow
// - Divided trigger unit still forwards timer requests
// - Then channel is last non-timer one, else zero
`timescale 1ns/1ps
`default_nettype none

module adc_chain_sequencer #(
    parameter int NUM_CH = adc_seq_pkg::NUM_CH_DEF,
    parameter int DATA_W = adc_seq_pkg::DATA_W_DEF,
    localparam int CHW = $clog2(NUM_CH)
) (
    // System
    input wire logic clock,
    input wire logic srst,
    // APB slave
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Cross trigger unit request
    input wire logic cross_trig_req,
    input wire logic [CHW-1:0] cross_trig_ch,
    // Body trigger unit sources
    input wire logic timer_trig_req,
    input wire logic [CHW-1:0] timer_trig_ch,
    input wire logic body_ext_req,
    input wire logic [CHW-1:0] body_ext_ch,
    // Converter data
    input wire logic [DATA_W-1:0] conv_data,
    // Converter control
    output logic sample_active,
    output logic convert_active,
    output logic [CHW-1:0] channel_select,
    // Chain end events
    output logic normal_chain_end_irq,
    output logic injected_chain_end_irq
);

    // Channel has no masked channel above it
    function automatic logic is_last(input logic [NUM_CH-1:0] m, input logic [CHW-1:0] c);
        logic r;
        r = 1'b1;
        for (int i = 0; i < NUM_CH; i++) begin
            if (i > int'(c) && m[i]) begin
                r = 1'b0;
            end
        end
        return r;
    endfunction

    // Register address match
    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        return a == off;
    endfunction

    // APB state
    logic pready_q; // Access phase answered
    logic [31:0] prdata_q; // Read data
    logic pslverr_q; // Unmapped address
    logic [31:0] rdata_d; // Read mux
    logic mapped_d; // Address decodes
    logic access; // Access phase
    logic wr_hs; // Write takes effect
    logic rd_hs; // Read completes
    logic res_hit; // Result window hit
    logic [7:0] res_off; // Offset into result window
    logic [CHW-1:0] res_idx; // Result channel addressed

    // Configuration
    logic scan_q; // Continuous scan of normal chain
    logic [adc_seq_pkg::DIV_W-1:0] div_q; // trigger_clock_divider
    logic [NUM_CH-1:0] nmask_q; // normal_channel_mask
    logic [NUM_CH-1:0] jmask_q; // injected_channel_mask
    logic normal_chain_running_flag_wr; // Software starts normal chain
    logic injected_chain_running_flag_wr; // Software starts injected chain

    // Sequencer state
    adc_seq_pkg::seq_state_type state_q; // Converter phase
    adc_seq_pkg::chain_kind_type kind_q; // Chain in service
    logic [CHW-1:0] ch_q; // Channel in service
    logic [3:0] cnt_q; // Phase cycles left
    logic nrun_q; // normal_chain_running_flag
    logic jrun_q; // injected_chain_running_flag
    logic [CHW-1:0] nptr_q; // Next normal channel
    logic [CHW-1:0] jptr_q; // Next injected channel
    logic tpend_q; // Trigger waiting
    logic [CHW-1:0] tch_q; // Channel of waiting trigger
    logic nirq_q; // normal_chain_end_irq
    logic jirq_q; // injected_chain_end_irq

    // Results
    logic [DATA_W-1:0] result_q [NUM_CH]; // channel_result_register data
    logic [NUM_CH-1:0] valid_q; // Result valid
    logic [NUM_CH-1:0] pend_q; // channel_pending_status
    logic [NUM_CH-1:0] lost_q; // Sample lost to preemption

    // Events
    logic preempt; // Running chain must yield
    logic done_evt; // Conversion completes
    logic lost_evt; // Conversion discarded
    logic [NUM_CH-1:0] cur_mask; // Mask of chain in service
    logic cur_last; // Channel in service is the last
    logic body_req; // Body trigger request
    logic [CHW-1:0] body_ch; // Body trigger channel

    // Outputs straight from flops
    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign sample_active = state_q[1];
    assign convert_active = state_q[2];
    assign channel_select = ch_q;
    assign normal_chain_end_irq = nirq_q;
    assign injected_chain_end_irq = jirq_q;

    // Timer and other body triggers
    body_trigger_unit #(
        .CHW(CHW)
    ) u_body (
        .clock(clock),
        .srst(srst),
        .trigger_clock_divider(div_q),
        .timer_req(timer_trig_req),
        .timer_ch(timer_trig_ch),
        .ext_req(body_ext_req),
        .ext_ch(body_ext_ch),
        .req(body_req),
        .ch(body_ch)
    );

    // Bus decode
    assign access = psel && penable;
    assign wr_hs = access && pready_q && pwrite && mapped_d;
    assign rd_hs = access && pready_q && !pwrite && mapped_d;
    assign res_off = paddr - adc_seq_pkg::OFF_RESULT;
    assign res_idx = res_off[CHW+1:2];
    assign res_hit = paddr >= adc_seq_pkg::OFF_RESULT && paddr[1:0] == 2'h0
        && res_off < 8'(4 * NUM_CH);
    assign normal_chain_running_flag_wr = wr_hs && hit(paddr, adc_seq_pkg::OFF_CTRL)
        && pwdata[adc_seq_pkg::CTRL_NORMAL_CHAIN_RUNNING_FLAG];
    assign injected_chain_running_flag_wr = wr_hs && hit(paddr, adc_seq_pkg::OFF_CTRL)
        && pwdata[adc_seq_pkg::CTRL_INJECTED_CHAIN_RUNNING_FLAG];

    // Read mux
    always_comb begin
        rdata_d = adc_seq_pkg::WORD_RST;
        mapped_d = 1'b1;
        if (hit(paddr, adc_seq_pkg::OFF_CTRL)) begin
            rdata_d[adc_seq_pkg::CTRL_SCAN] = scan_q;
            rdata_d[adc_seq_pkg::CTRL_DIV_LSB +: adc_seq_pkg::DIV_W] = div_q;
        end else if (hit(paddr, adc_seq_pkg::OFF_STATUS)) begin
            rdata_d[adc_seq_pkg::STAT_NRUN] = nrun_q;
            rdata_d[adc_seq_pkg::STAT_JRUN] = jrun_q;
            rdata_d[adc_seq_pkg::STAT_TPEND] = tpend_q;
            rdata_d[adc_seq_pkg::STAT_CH_LSB +: CHW] = ch_q;
        end else if (hit(paddr, adc_seq_pkg::OFF_NMASK)) begin
            rdata_d[NUM_CH-1:0] = nmask_q;
        end else if (hit(paddr, adc_seq_pkg::OFF_JMASK)) begin
            rdata_d[NUM_CH-1:0] = jmask_q;
        end else if (hit(paddr, adc_seq_pkg::OFF_PEND)) begin
            rdata_d[NUM_CH-1:0] = pend_q;
        end else if (hit(paddr, adc_seq_pkg::OFF_LOST)) begin
            rdata_d[NUM_CH-1:0] = lost_q;
        end else if (res_hit) begin
            rdata_d[adc_seq_pkg::RES_VALID] = valid_q[res_idx];
            rdata_d[DATA_W-1:0] = result_q[res_idx];
        end else begin
            // Unmapped: zero data and error
            mapped_d = 1'b0;
        end
    end

    // APB answer: one wait state, data captured in the first access cycle
    always_ff @(posedge clock) begin
        if (srst) begin
            pready_q <= 1'b0;
            prdata_q <= adc_seq_pkg::WORD_RST;
            pslverr_q <= 1'b0;
        end else begin
            pready_q <= access && !pready_q;
            if (access && !pready_q) begin
                prdata_q <= rdata_d;
                pslverr_q <= !mapped_d;
            end else begin
                pslverr_q <= 1'b0;
            end
        end
    end

    // Configuration registers
    always_ff @(posedge clock) begin
        if (srst) begin
            scan_q <= 1'b0;
            div_q <= adc_seq_pkg::DIV_FULL_RATE;
            nmask_q <= '0;
            jmask_q <= '0;
        end else if (wr_hs) begin
            if (hit(paddr, adc_seq_pkg::OFF_CTRL)) begin
                scan_q <= pwdata[adc_seq_pkg::CTRL_SCAN];
                div_q <= pwdata[adc_seq_pkg::CTRL_DIV_LSB +: adc_seq_pkg::DIV_W];
            end
            if (hit(paddr, adc_seq_pkg::OFF_NMASK)) begin
                nmask_q <= pwdata[NUM_CH-1:0];
            end
            if (hit(paddr, adc_seq_pkg::OFF_JMASK)) begin
                jmask_q <= pwdata[NUM_CH-1:0];
            end
        end
    end

    // Trigger beats injected beats normal; a trigger is never preempted
    assign preempt = state_q != adc_seq_pkg::ST_IDLE
        && ((tpend_q && kind_q != adc_seq_pkg::K_TRIG)
        || (jrun_q && kind_q == adc_seq_pkg::K_NORM));
    assign cur_mask = kind_q == adc_seq_pkg::K_INJ ? jmask_q : nmask_q;
    assign cur_last = is_last(cur_mask, ch_q);
    assign done_evt = state_q == adc_seq_pkg::ST_CONVERT && cnt_q == 4'h0 && !preempt;
    assign lost_evt = state_q == adc_seq_pkg::ST_CONVERT && preempt;

    // Chain sequencer
    always_ff @(posedge clock) begin
        if (srst) begin
            state_q <= adc_seq_pkg::ST_IDLE;
            kind_q <= adc_seq_pkg::K_NORM;
            ch_q <= '0;
            cnt_q <= 4'h0;
            nrun_q <= 1'b0;
            jrun_q <= 1'b0;
            nptr_q <= '0;
            jptr_q <= '0;
            tpend_q <= 1'b0;
            tch_q <= '0;
            nirq_q <= 1'b0;
            jirq_q <= 1'b0;
        end else begin
            nirq_q <= 1'b0;
            jirq_q <= 1'b0;
            case (state_q)
                adc_seq_pkg::ST_IDLE: begin
                    // Pick highest-priority work, skipping unmasked channels
                    if (tpend_q) begin
                        kind_q <= adc_seq_pkg::K_TRIG;
                        ch_q <= tch_q;
                        tpend_q <= 1'b0;
                        state_q <= adc_seq_pkg::ST_SAMPLE;
                        cnt_q <= adc_seq_pkg::SAMPLE_CYCLES - 4'h1;
                    end else if (jrun_q) begin
                        if (jmask_q[jptr_q]) begin
                            kind_q <= adc_seq_pkg::K_INJ;
                            ch_q <= jptr_q;
                            state_q <= adc_seq_pkg::ST_SAMPLE;
                            cnt_q <= adc_seq_pkg::SAMPLE_CYCLES - 4'h1;
                        end else begin
                            jptr_q <= CHW'(jptr_q + 1'b1);
                        end
                    end else if (nrun_q) begin
                        if (nmask_q[nptr_q]) begin
                            kind_q <= adc_seq_pkg::K_NORM;
                            ch_q <= nptr_q;
                            state_q <= adc_seq_pkg::ST_SAMPLE;
                            cnt_q <= adc_seq_pkg::SAMPLE_CYCLES - 4'h1;
                        end else begin
                            nptr_q <= CHW'(nptr_q + 1'b1);
                        end
                    end
                end
                adc_seq_pkg::ST_SAMPLE: begin
                    if (preempt) begin
                        // Pointer untouched so the channel is restored later
                        state_q <= adc_seq_pkg::ST_IDLE;
                        if (cur_last) begin
                            // Early end event, flag kept set
                            nirq_q <= kind_q == adc_seq_pkg::K_NORM;
                            jirq_q <= kind_q == adc_seq_pkg::K_INJ;
                        end
                    end else if (cnt_q == 4'h0) begin
                        state_q <= adc_seq_pkg::ST_CONVERT;
                        cnt_q <= adc_seq_pkg::CONVERT_CYCLES - 4'h1;
                    end else begin
                        cnt_q <= cnt_q - 4'h1;
                    end
                end
                adc_seq_pkg::ST_CONVERT: begin
                    if (preempt) begin
                        // Sample dropped, never restored
                        state_q <= adc_seq_pkg::ST_IDLE;
                        if (!cur_last) begin
                            if (kind_q == adc_seq_pkg::K_INJ) begin
                                jptr_q <= CHW'(ch_q + 1'b1);
                            end else begin
                                nptr_q <= CHW'(ch_q + 1'b1);
                            end
                        end else if (kind_q == adc_seq_pkg::K_NORM && scan_q) begin
                            // End event now; restart raises no second
                            nirq_q <= 1'b1;
                            nptr_q <= '0;
                        end else if (kind_q == adc_seq_pkg::K_INJ) begin
                            // Whole chain again, event at its end
                            jptr_q <= '0;
                        end else begin
                            nptr_q <= '0;
                        end
                    end else if (cnt_q == 4'h0) begin
                        state_q <= adc_seq_pkg::ST_IDLE;
                        if (kind_q != adc_seq_pkg::K_TRIG && cur_last) begin
                            // Chain complete: its own event type
                            if (kind_q == adc_seq_pkg::K_INJ) begin
                                jirq_q <= 1'b1;
                                jptr_q <= '0;
                                jrun_q <= 1'b0;
                            end else begin
                                nirq_q <= 1'b1;
                                nptr_q <= '0;
                                nrun_q <= scan_q;
                            end
                        end else if (kind_q == adc_seq_pkg::K_INJ) begin
                            jptr_q <= CHW'(ch_q + 1'b1);
                        end else if (kind_q == adc_seq_pkg::K_NORM) begin
                            nptr_q <= CHW'(ch_q + 1'b1);
                        end
                    end else begin
                        cnt_q <= cnt_q - 4'h1;
                    end
                end
                default: begin
                    state_q <= adc_seq_pkg::ST_IDLE;
                end
            endcase
            // New trigger wins over the take above; cross trigger first
            if (cross_trig_req) begin
                tpend_q <= 1'b1;
                tch_q <= cross_trig_ch;
            end else if (body_req) begin
                tpend_q <= 1'b1;
                tch_q <= body_ch;
            end
            // Software start of an idle chain with a non-empty mask
            if (normal_chain_running_flag_wr && !nrun_q && nmask_q != '0) begin
                nrun_q <= 1'b1;
                nptr_q <= '0;
            end
            if (injected_chain_running_flag_wr && !jrun_q && jmask_q != '0) begin
                jrun_q <= 1'b1;
                jptr_q <= '0;
            end
        end
    end

    // Results, pending and lost flags; hardware set beats software clear
    always_ff @(posedge clock) begin
        if (srst) begin
            valid_q <= '0;
            pend_q <= '0;
            lost_q <= '0;
            for (int i = 0; i < NUM_CH; i++) begin
                result_q[i] <= '0;
            end
        end else begin
            if (wr_hs && hit(paddr, adc_seq_pkg::OFF_PEND)) begin
                pend_q <= pend_q & ~pwdata[NUM_CH-1:0];
            end
            if (wr_hs && hit(paddr, adc_seq_pkg::OFF_LOST)) begin
                lost_q <= lost_q & ~pwdata[NUM_CH-1:0];
            end
            // Reading a result consumes its valid bit
            if (rd_hs && res_hit) begin
                valid_q[res_idx] <= 1'b0;
            end
            if (done_evt) begin
                result_q[ch_q] <= conv_data;
                valid_q[ch_q] <= 1'b1;
                pend_q[ch_q] <= 1'b1;
            end
            // Lost sample: no valid, no pending
            if (lost_evt) begin
                lost_q[ch_q] <= 1'b1;
            end
        end
    end

    AST_TRIG_PREEMPTS: assert property (@(posedge clock) disable iff (srst)
        state_q != adc_seq_pkg::ST_IDLE && tpend_q && kind_q != adc_seq_pkg::K_TRIG
        |=> state_q == adc_seq_pkg::ST_IDLE ##1 kind_q == adc_seq_pkg::K_TRIG)
        else $error("trigger did not preempt");

    AST_LOST_DISCARDED: assert property (@(posedge clock) disable iff (srst)
        lost_evt |=> lost_q[$past(ch_q)] && state_q == adc_seq_pkg::ST_IDLE)
        else $error("lost sample not discarded");

    AST_LOST_NOT_PENDING: assert property (@(posedge clock) disable iff (srst)
        lost_evt && !pend_q[ch_q] && !valid_q[ch_q]
        |=> !pend_q[$past(ch_q)] && !valid_q[$past(ch_q)])
        else $error("lost sample flagged");

    AST_SAMPLE_EARLY_NORMAL: assert property (@(posedge clock) disable iff (srst)
        state_q == adc_seq_pkg::ST_SAMPLE && preempt && cur_last
        && kind_q == adc_seq_pkg::K_NORM |=> normal_chain_end_irq && nrun_q)
        else $error("no early normal end event");

    AST_SAMPLE_EARLY_INJ: assert property (@(posedge clock) disable iff (srst)
        state_q == adc_seq_pkg::ST_SAMPLE && preempt && cur_last
        && kind_q == adc_seq_pkg::K_INJ |=> injected_chain_end_irq ##1 jrun_q)
        else $error("no early injected end event");

    AST_SCAN_NO_SECOND: assert property (@(posedge clock) disable iff (srst)
        lost_evt && cur_last && scan_q && kind_q == adc_seq_pkg::K_NORM
        |=> normal_chain_end_irq && nptr_q == '0 && nrun_q)
        else $error("scan preemption handling wrong");

    AST_ONESHOT_RESTART: assert property (@(posedge clock) disable iff (srst)
        lost_evt && cur_last && !scan_q && kind_q == adc_seq_pkg::K_NORM
        |=> !normal_chain_end_irq && nptr_q == '0 && nrun_q)
        else $error("one-shot chain not restarted");

    AST_FLAG_HELD: assert property (@(posedge clock) disable iff (srst)
        normal_chain_end_irq && $past(state_q) == adc_seq_pkg::ST_SAMPLE |-> nrun_q)
        else $error("running flag cleared too early");

    AST_SEPARATE_EVENTS: assert property (@(posedge clock) disable iff (srst)
        done_evt && cur_last && kind_q == adc_seq_pkg::K_INJ
        |=> injected_chain_end_irq && !normal_chain_end_irq)
        else $error("injected end on wrong output");

endmodule

`default_nettype wire

// ### verif/trig_source_model.sv
`timescale 1ns/1ps
`default_nettype none
// Trigger sources: one request of the asked kind while go is high
module trig_source_model (
    // System
    input wire logic clock,
    // Command from the bench
    input wire logic [1:0] kind,
    input wire logic [2:0] chan,
    input wire logic go,
    // Requests and their shared channel
    output logic cross_req,
    output logic timer_req,
    output logic ext_req,
    output logic [2:0] ch
);
    logic [2:0] idle_q = 3'h0; // Changing pattern outside a request
    // Channel lines carry no stale value between pulses
    always_ff @(posedge clock) begin
        idle_q <= idle_q + 3'h3;
    end
    assign cross_req = go && (kind == 2'h0);
    assign timer_req = go && (kind == 2'h1);
    assign ext_req = go && (kind == 2'h2);
    assign ch = go ? chan : idle_q;
endmodule
`default_nettype wire

// ### verif/adc_chain_preemption_sequencer_bench.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, x, g) begin cmp_count++; if ((g) !== (x)) begin n_fail++; \
    $display("CHECK FAILED %s exp %h got %h", nm, x, g); end end
module adc_chain_preemption_sequencer_bench;
    logic clock, srst, psel, penable, pwrite, go, cr, tr, er, sa, ca, ni, ji, pready, pslverr, e;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, r;
    logic [1:0] kind;
    logic [2:0] chan, tch, sel;
    logic [9:0] conv_data;
    int n_fail, cmp_count, cyc, n_ni, n_ji;
    trig_source_model trig_source_model_inst (.clock(clock), .kind(kind), .chan(chan),
        .go(go), .cross_req(cr), .timer_req(tr), .ext_req(er), .ch(tch));
    adc_chain_sequencer adc_chain_sequencer_inst (.clock(clock), .srst(srst), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .cross_trig_req(cr), .cross_trig_ch(tch),
        .timer_trig_req(tr), .timer_trig_ch(tch), .body_ext_req(er), .body_ext_ch(tch),
        .conv_data(conv_data), .sample_active(sa), .convert_active(ca),
        .channel_select(sel), .normal_chain_end_irq(ni), .injected_chain_end_irq(ji));
    // System clock, 20 ns period
    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end
    // Chain end pulse counting and run limit
    always @(posedge clock) begin
        cyc++;
        n_ni += ni;
        n_ji += ji;
        if (cyc == 5000) begin
            n_fail++;
            test_done();
        end
    end
    // One APB transfer; read data in r, error flag in e
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        // Request held until pready is seen high at a rising edge
        do begin
            @(posedge clock);
        end while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // One request pulse from the trigger model
    task automatic trig(input logic [1:0] k, input logic [2:0] c);
        @(posedge clock);
        kind <= k;
        chan <= c;
        go <= 1'b1;
        @(posedge clock);
        go <= 1'b0;
    endtask
    // Bounded wait for a level to go high
    task automatic rise(ref logic s);
        int n;
        n = 0;
        while (s !== 1'b1 && n < 200) begin
            @(negedge clock);
            n++;
        end
    endtask
    // Counts, verdict and end of run
    task automatic test_done();
        $display("checks %0d failures %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // Main sequence
    initial begin
        srst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        kind = 2'h0;
        chan = 3'h0;
        go = 1'b0;
        conv_data = 10'h2A5;
        repeat (16) @(posedge clock);
        srst <= 1'b0;
        apb(0, 8'h04, 32'h0);
        `CHK("status", 32'h0, r)
        apb(0, 8'h18, 32'h0);
        `CHK("unmapped", 1'b1, e)
        trig(2'h0, 3'h5);
        rise(ca);
        repeat (20) @(posedge clock);
        apb(0, 8'h34, 32'h0);
        `CHK("result5", 32'h8000_02A5, r)
        apb(1, 8'h10, 32'hFF);
        apb(1, 8'h08, 32'h04);
        apb(1, 8'h00, 32'h01);
        rise(ca);
        trig(2'h0, 3'h5);
        apb(0, 8'h10, 32'h0);
        `CHK("missed", 32'h04, 32'h04 & (32'h04 ^ r))
        repeat (60) @(posedge clock);
        apb(0, 8'h14, 32'h0);
        `CHK("lost", 32'h04, r)
        `CHK("one-shot ends", 1, n_ni)
        apb(1, 8'h00, 32'h01);
        rise(sa);
        trig(2'h0, 3'h5);
        apb(0, 8'h04, 32'h0);
        `CHK("running", 1'b1, r[0])
        repeat (60) @(posedge clock);
        `CHK("two ends", 3, n_ni)
        `CHK("injected ends", 0, n_ji)
        // Injected chain on channel 3, preempted while sampling its last channel
        apb(1, 8'h0C, 32'h08);
        apb(1, 8'h00, 32'h02);
        rise(sa);
        trig(2'h0, 3'h5);
        repeat (60) @(posedge clock);
        `CHK("injected two ends", 2, n_ji)
        // Scan chain preempted in conversion of its last channel, then scan off
        apb(1, 8'h00, 32'h05);
        rise(ca);
        trig(2'h0, 3'h5);
        apb(1, 8'h00, 32'h00);
        repeat (60) @(posedge clock);
        `CHK("scan ends", 5, n_ni)
        apb(1, 8'h00, 32'h10);
        trig(2'h2, 3'h3);
        repeat (30) @(posedge clock);
        trig(2'h1, 3'h6);
        rise(sa);
        `CHK("timer forwarded", 1'b1, sa)
        `CHK("timer ch divided", 3'h3, sel)
        repeat (30) @(posedge clock);
        apb(1, 8'h00, 32'h00);
        trig(2'h1, 3'h6);
        rise(sa);
        `CHK("timer ch full", 3'h6, sel)
        test_done();
    end
endmodule
`default_nettype wire
